// file: hdl/poca_pkg.sv
// constants and types for the pixel output clock align block
// assumes a single 200 MHz core clock and a host on the 2-wire serial port
// Behaviour
// - fixed latency from sample to output buses
// - phase move shifts data, strobe, sync together
// - strobe source from output_clock_config bits 7:6
// - pixel, 90-degree and double-rate strobe choices
// - fourth choice is internal half-rate clock
// - sampling_phase_adjust sets sampling instant and strobe
// - all controls reachable over 2-wire serial port
// - three 8-bit buses: red, green, blue
// - output path runs at a fixed 50 MHz pixel rate, one pixel per 4 core clocks
// - regenerated sync: programmable polarity and duration
package poca_pkg;
  localparam int CLK_MHZ = 200;
  localparam int PIX_MHZ = 50;
  localparam int PIX_DIV = CLK_MHZ / PIX_MHZ;
  localparam int PIPE_LAT = 2;
  localparam logic [7:0] OFS_PHASE = 8'h04;
  localparam logic [7:0] OFS_CLKCFG = 8'h20;
  localparam logic [7:0] OFS_HSCFG = 8'h12;
  localparam logic [7:0] OFS_HSDUR = 8'h13;
  localparam int PHASE_MSB = 7;
  localparam int PHASE_LSB = 6;
  localparam int CLKSEL_MSB = 7;
  localparam int CLKSEL_LSB = 6;
  localparam int HSPOL_BIT = 7;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_CLKCFG = 8'h00;
  localparam logic [7:0] RST_HSCFG = 8'h00;
  localparam logic [7:0] RST_HSDUR = 8'h10;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // device address on the serial port; value is arbitrary
  localparam logic [6:0] SER_ADDR = 7'h4c;

  typedef enum logic [1:0] {
    POCA_CK_PIX = 2'b00,
    POCA_CK_SHIFT = 2'b01,
    POCA_CK_DOUBLE = 2'b10,
    POCA_CK_HALF = 2'b11
  } poca_cksel_t;

  typedef enum logic [3:0] {
    POCA_S_IDLE = 4'b0000,
    POCA_S_ADDR = 4'b0001,
    POCA_S_ACK_A = 4'b0010,
    POCA_S_PTR = 4'b0011,
    POCA_S_ACK_P = 4'b0100,
    POCA_S_WDATA = 4'b0101,
    POCA_S_ACK_W = 4'b0110,
    POCA_S_RDATA = 4'b0111,
    POCA_S_RACK = 4'b1000
  } poca_ser_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic hsync;
  } poca_pix_t;
endpackage : poca_pkg

// file: hdl/poca_top.sv
// output stage: pixel buses, regenerated line sync, strobe clock, serial registers
// assumes pixel words arrive from converter logic on MCLK; pins are asynchronous
`timescale 1ns/100ps
module poca_top (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] RED_IN,
  input wire logic [7:0] GREEN_IN,
  input wire logic [7:0] BLUE_IN,
  input wire logic LINE_SYNC_IN,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  output logic [7:0] RED,
  output logic [7:0] GREEN,
  output logic [7:0] BLUE,
  output logic REGENERATED_LINE_SYNC_OUT,
  output logic OUTPUT_STROBE_CLOCK,
  output logic SAMPLE_EN
);
  typedef poca_pkg::poca_pix_t poca_pix_t;

  logic [7:0] phase_r;
  logic [7:0] clkcfg_r;
  logic [7:0] hscfg_r;
  logic [7:0] hsdur_r;
  logic [1:0] scl_m_r, sda_m_r;
  logic scl_q_r, sda_q_r;
  logic ls_m_r, ls_s_r;
  poca_pkg::poca_ser_t st_r;
  logic [2:0] bitc_r;
  logic [7:0] sr_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic ackrise_r;
  logic fall_d_r;
  logic [1:0] ph_cnt_r;
  logic [1:0] rel;
  logic [1:0] samp_ph;
  logic samp_en;
  logic half_r;
  logic [7:0] hs_cnt_r;
  logic hs_prev_r;
  poca_pix_t cap_r;
  poca_pix_t pipe_r [poca_pkg::PIPE_LAT];
  logic strobe_nxt;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] byte_c;
  logic [7:0] rd_c;

  // pin synchronisers: first stage feeds only the second
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      scl_m_r <= 2'h3;
      sda_m_r <= 2'h3;
      ls_m_r <= 1'b0;
      ls_s_r <= 1'b0;
    end else begin
      scl_m_r <= {scl_m_r[0], SCL};
      sda_m_r <= {sda_m_r[0], SDA_I};
      ls_m_r <= LINE_SYNC_IN;
      ls_s_r <= ls_m_r;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_m_r[1];
      sda_q_r <= sda_m_r[1];
    end
  end

  assign scl_rise = scl_m_r[1] & ~scl_q_r;
  assign scl_fall = ~scl_m_r[1] & scl_q_r;
  assign start_c = scl_m_r[1] & scl_q_r & sda_q_r & ~sda_m_r[1];
  assign stop_c = scl_m_r[1] & scl_q_r & ~sda_q_r & sda_m_r[1];
  assign byte_c = {sr_r[6:0], sda_m_r[1]};

  // register read mux; unmapped offsets read as zero
  always_comb begin
    case (ptr_r)
      poca_pkg::OFS_PHASE: rd_c = phase_r;
      poca_pkg::OFS_CLKCFG: rd_c = clkcfg_r;
      poca_pkg::OFS_HSCFG: rd_c = hscfg_r;
      poca_pkg::OFS_HSDUR: rd_c = hsdur_r;
      default: rd_c = poca_pkg::RD_UNMAPPED;
    endcase
  end

  // serial port slave: pointer byte then data bytes, pointer auto-increments
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_r <= poca_pkg::POCA_S_IDLE;
      bitc_r <= 3'h0;
      sr_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      ackrise_r <= 1'b0;
    end else if (start_c) begin
      st_r <= poca_pkg::POCA_S_ADDR;
      bitc_r <= 3'h0;
      ackrise_r <= 1'b0;
    end else if (stop_c) begin
      st_r <= poca_pkg::POCA_S_IDLE;
    end else if (scl_rise) begin
      sr_r <= byte_c;
      bitc_r <= bitc_r + 3'h1;
      case (st_r)
        poca_pkg::POCA_S_ADDR: begin
          if (bitc_r == 3'h7) begin
            if (byte_c[7:1] == poca_pkg::SER_ADDR) begin
              st_r <= poca_pkg::POCA_S_ACK_A;
              rw_r <= byte_c[0];
            end else begin
              st_r <= poca_pkg::POCA_S_IDLE;
            end
          end
        end
        poca_pkg::POCA_S_PTR: begin
          if (bitc_r == 3'h7) begin
            ptr_r <= byte_c;
            st_r <= poca_pkg::POCA_S_ACK_P;
          end
        end
        poca_pkg::POCA_S_WDATA: begin
          if (bitc_r == 3'h7) begin
            st_r <= poca_pkg::POCA_S_ACK_W;
          end
        end
        poca_pkg::POCA_S_RDATA: begin
          tx_r <= {tx_r[6:0], 1'b0};
          if (bitc_r == 3'h7) begin
            st_r <= poca_pkg::POCA_S_RACK;
          end
        end
        poca_pkg::POCA_S_RACK: begin
          bitc_r <= 3'h0;
          if (sda_m_r[1]) begin
            st_r <= poca_pkg::POCA_S_IDLE;
          end else begin
            st_r <= poca_pkg::POCA_S_RDATA;
            tx_r <= rd_c;
          end
        end
        poca_pkg::POCA_S_ACK_A, poca_pkg::POCA_S_ACK_P, poca_pkg::POCA_S_ACK_W: begin
          ackrise_r <= 1'b1;
          bitc_r <= 3'h0;
        end
        default: begin
          bitc_r <= 3'h0;
        end
      endcase
    end else if (scl_fall) begin
      case (st_r)
        poca_pkg::POCA_S_ACK_A: begin
          if (ackrise_r) begin
            ackrise_r <= 1'b0;
            st_r <= rw_r ? poca_pkg::POCA_S_RDATA : poca_pkg::POCA_S_PTR;
            tx_r <= rd_c;
          end
        end
        poca_pkg::POCA_S_ACK_P: begin
          if (ackrise_r) begin
            ackrise_r <= 1'b0;
            st_r <= poca_pkg::POCA_S_WDATA;
          end
        end
        poca_pkg::POCA_S_ACK_W: begin
          if (ackrise_r) begin
            ackrise_r <= 1'b0;
            st_r <= poca_pkg::POCA_S_WDATA;
            ptr_r <= ptr_r + 8'h01;
          end
        end
        poca_pkg::POCA_S_RACK: begin
          if (!ackrise_r) begin
            ptr_r <= ptr_r + 8'h01;
            ackrise_r <= 1'b1;
          end
        end
        default: begin
          ackrise_r <= 1'b0;
        end
      endcase
    end
  end

  // open-drain data line: only ever pulls low, changes after scl falls
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      fall_d_r <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else begin
      fall_d_r <= scl_fall;
      if (start_c || stop_c) begin
        SDA_OE_N <= 1'b1;
      end else if (fall_d_r) begin
        case (st_r)
          poca_pkg::POCA_S_ACK_A, poca_pkg::POCA_S_ACK_P, poca_pkg::POCA_S_ACK_W:
            SDA_OE_N <= ackrise_r;
          poca_pkg::POCA_S_RDATA: SDA_OE_N <= tx_r[7];
          default: SDA_OE_N <= 1'b1;
        endcase
      end
    end
  end

  assign SDA_O = 1'b0;

  // register writes land on the eighth data bit
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      phase_r <= poca_pkg::RST_PHASE;
      clkcfg_r <= poca_pkg::RST_CLKCFG;
      hscfg_r <= poca_pkg::RST_HSCFG;
      hsdur_r <= poca_pkg::RST_HSDUR;
    end else if (scl_rise && st_r == poca_pkg::POCA_S_WDATA && bitc_r == 3'h7) begin
      case (ptr_r)
        poca_pkg::OFS_PHASE: phase_r <= byte_c;
        poca_pkg::OFS_CLKCFG: clkcfg_r <= byte_c;
        poca_pkg::OFS_HSCFG: hscfg_r <= byte_c;
        poca_pkg::OFS_HSDUR: hsdur_r <= byte_c;
        default: ;
      endcase
    end
  end

  // pixel timing: one pixel per PIX_DIV clocks; the fast core clock leaves the
  // strobe edges on a quarter-pixel grid, so only the top phase bits take effect
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ph_cnt_r <= 2'h0;
    end else begin
      ph_cnt_r <= ph_cnt_r + 2'h1;
    end
  end

  assign samp_ph = phase_r[poca_pkg::PHASE_MSB:poca_pkg::PHASE_LSB];
  assign samp_en = (ph_cnt_r == samp_ph);
  assign rel = ph_cnt_r - samp_ph;

  // capture and fixed pipeline, all stepping on the moved sample enable
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      cap_r <= '0;
      for (int i = 0; i < poca_pkg::PIPE_LAT; i++) begin
        pipe_r[i] <= '0;
      end
    end else if (samp_en) begin
      cap_r <= '{red: RED_IN, green: GREEN_IN, blue: BLUE_IN,
                 hsync: (hs_cnt_r != 8'h00) ^ hscfg_r[poca_pkg::HSPOL_BIT]};
      pipe_r[0] <= cap_r;
      for (int i = 1; i < poca_pkg::PIPE_LAT; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  // sync regeneration: leading edge starts a pulse of hsdur_r pixels
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      hs_prev_r <= 1'b0;
      hs_cnt_r <= 8'h00;
    end else if (samp_en) begin
      hs_prev_r <= ls_s_r;
      if (ls_s_r && !hs_prev_r) begin
        hs_cnt_r <= hsdur_r;
      end else if (hs_cnt_r != 8'h00) begin
        hs_cnt_r <= hs_cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      half_r <= 1'b0;
    end else if (samp_en) begin
      half_r <= ~half_r;
    end
  end

  // strobe phase measured from the sample enable, so it moves with the data
  always_comb begin
    case (poca_pkg::poca_cksel_t'(clkcfg_r[poca_pkg::CLKSEL_MSB:poca_pkg::CLKSEL_LSB]))
      poca_pkg::POCA_CK_PIX: strobe_nxt = (rel >= 2'h2);
      poca_pkg::POCA_CK_SHIFT: strobe_nxt = (rel == 2'h0) || (rel == 2'h3);
      poca_pkg::POCA_CK_DOUBLE: strobe_nxt = rel[0];
      poca_pkg::POCA_CK_HALF: strobe_nxt = half_r;
      default: strobe_nxt = 1'b0;
    endcase
  end

  // outputs leave flip-flops on one clock edge so their skew stays fixed
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RED <= 8'h00;
      GREEN <= 8'h00;
      BLUE <= 8'h00;
      REGENERATED_LINE_SYNC_OUT <= 1'b0;
      OUTPUT_STROBE_CLOCK <= 1'b0;
      SAMPLE_EN <= 1'b0;
    end else begin
      RED <= pipe_r[poca_pkg::PIPE_LAT-1].red;
      GREEN <= pipe_r[poca_pkg::PIPE_LAT-1].green;
      BLUE <= pipe_r[poca_pkg::PIPE_LAT-1].blue;
      REGENERATED_LINE_SYNC_OUT <= pipe_r[poca_pkg::PIPE_LAT-1].hsync;
      OUTPUT_STROBE_CLOCK <= strobe_nxt;
      SAMPLE_EN <= samp_en;
    end
  end
endmodule : poca_top

// file: sim/poca_top_checker.sv
// checker: pixel cadence, strobe activity, serial pin drive
// bound into poca_top; sees its ports only
`timescale 1ns/100ps
module poca_top_checker (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] RED_IN,
  input wire logic [7:0] GREEN_IN,
  input wire logic [7:0] BLUE_IN,
  input wire logic LINE_SYNC_IN,
  input wire logic SCL,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N,
  input wire logic [7:0] RED,
  input wire logic [7:0] GREEN,
  input wire logic [7:0] BLUE,
  input wire logic REGENERATED_LINE_SYNC_OUT,
  input wire logic OUTPUT_STROBE_CLOCK,
  input wire logic SAMPLE_EN
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  // data buses and sync may only move at the pixel boundary, whatever the phase
  sequence s_pix_edge;
    SAMPLE_EN || $past(SAMPLE_EN);
  endsequence
  sequence s_ack_hold;
    !SDA_OE_N [*8];
  endsequence
  sequence s_listen;
    SDA_OE_N [*8];
  endsequence
  a_reset_clear: assert property (disable iff (1'b0) !RST_N |=> RED == 8'h00
    && GREEN == 8'h00 && BLUE == 8'h00 && SDA_OE_N) else $error("not cleared");
  a_data_cadence: assert property ($changed({RED, GREEN, BLUE}) |-> s_pix_edge)
    else $error("buses off boundary");
  a_sync_align: assert property ($changed(REGENERATED_LINE_SYNC_OUT) |-> s_pix_edge)
    else $error("sync off boundary");
  a_strobe_alive: assert property (SAMPLE_EN |-> ##[1:8] $changed(OUTPUT_STROBE_CLOCK))
    else $error("strobe stopped");
  a_ack_hold: assert property ($fell(SDA_OE_N) |=> s_ack_hold)
    else $error("pull too short");
  a_sda_zero: assert property (SDA_O == 1'b0)
    else $error("data pin high");
  a_sda_quiet: assert property ($changed(SDA_OE_N) |-> !SCL && $past(SCL, 2) == 1'b0)
    else $error("data moved with clock high");
  a_start_listen: assert property ($fell(SDA_I) && SCL |=> s_listen)
    else $error("pull during address");
endmodule : poca_top_checker
bind poca_top poca_top_checker u_chk (.MCLK, .RST_N, .RED_IN, .GREEN_IN, .BLUE_IN,
  .LINE_SYNC_IN, .SCL, .SDA_I, .SDA_O, .SDA_OE_N, .RED, .GREEN, .BLUE,
  .REGENERATED_LINE_SYNC_OUT, .OUTPUT_STROBE_CLOCK, .SAMPLE_EN);

// file: sim/poca_sink.sv
// downstream capture model: takes buses and sync on each strobe rise
// strobe sampled on the core clock so data and strobe never race
`timescale 1ns/100ps
module poca_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe,
  input wire poca_pkg::poca_pix_t pix,
  output poca_pkg::poca_pix_t got,
  output logic [15:0] rises
);
  logic prev_r;
  always_ff @(posedge clk) begin
    prev_r <= strobe;
    if (!rst_n) begin
      rises <= 16'h0000;
    end else if (strobe && !prev_r) begin
      got <= pix;
      rises <= rises + 16'h0001;
    end
  end
endmodule : poca_sink

// file: sim/testbench.sv
// bench: serial host, table of pixel cases, sync, address and reset cases
// assumes poca_top, poca_sink and the bound checker
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [7:0] ph;
    logic [7:0] cfg;
    logic [23:0] rgb;
    logic [7:0] rise;
  } poca_row_t;
  poca_row_t rows [4] = '{'{8'h00, 8'h00, 24'h123456, 8'h08}, '{8'h40, 8'h40, 24'ha5c3e1, 8'h08},
    '{8'h80, 8'h80, 24'h0f1e2d, 8'h10}, '{8'hc0, 8'hc0, 24'hf0e1d2, 8'h04}};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic scl = 1'b1;
  logic sda_h = 1'b1;
  logic sync_in = 1'b0;
  logic [23:0] rgb_in = 24'h000000;
  logic sda_o, sda_oe_n, sync_out, strobe, smp, a;
  logic [23:0] rgb_out;
  logic [7:0] r;
  logic [15:0] rises, base;
  poca_pkg::poca_pix_t got;
  wire sda_w = sda_h & sda_oe_n;
  int bad_count = 0;
  int checked = 0;
  int n;
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  poca_top dut (.MCLK(mclk), .RST_N(rst_n), .RED_IN(rgb_in[23:16]), .GREEN_IN(rgb_in[15:8]),
    .BLUE_IN(rgb_in[7:0]), .LINE_SYNC_IN(sync_in), .SCL(scl), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_N(sda_oe_n), .RED(rgb_out[23:16]), .GREEN(rgb_out[15:8]), .BLUE(rgb_out[7:0]),
    .REGENERATED_LINE_SYNC_OUT(sync_out), .OUTPUT_STROBE_CLOCK(strobe), .SAMPLE_EN(smp));
  poca_sink u_sink (.clk(mclk), .rst_n(rst_n), .strobe(strobe), .pix({rgb_out, sync_out}),
    .got(got), .rises(rises));
  task automatic wt(input int c);
    repeat (c) @(negedge mclk);
  endtask : wt
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %0t saw %0h want %0h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // pins change only at falling core edges; line levels held 6 cycles or more
  task automatic lv(input logic c, input logic d);
    wt(6);
    scl = c;
    sda_h = d;
  endtask : lv
  task automatic xb(input logic [7:0] b, input logic ha);
    // eight data bits msb first, then the acknowledge slot
    for (int i = 7; i >= -1; i--) begin
      lv(1'b0, i < 0 ? ha : b[i]);
      lv(1'b1, i < 0 ? ha : b[i]);
      wt(3);
      if (i < 0) a = sda_w;
      else r[i] = sda_w;
      wt(3);
      scl = 1'b0;
    end
  endtask : xb
  task automatic start;
    lv(1'b0, 1'b1);
    lv(1'b1, 1'b1);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b0);
  endtask : start
  task automatic stop;
    lv(1'b0, 1'b0);
    lv(1'b1, 1'b0);
    lv(1'b1, 1'b1);
  endtask : stop
  task automatic xfer(input logic [7:0] o, input logic [7:0] d, input logic rd);
    start;
    xb({poca_pkg::SER_ADDR, 1'b0}, 1'b1);
    chk(a, 0);
    xb(o, 1'b1);
    chk(a, 0);
    if (rd) begin
      start;
      xb({poca_pkg::SER_ADDR, 1'b1}, 1'b1);
      chk(a, 0);
    end
    xb(d, 1'b1);
    chk(a, rd);
    stop;
  endtask : xfer
  task automatic rdc(input logic [7:0] o, input logic [7:0] e);
    xfer(o, 8'hff, 1'b1);
    chk(r, e);
  endtask : rdc
  initial begin
    wt(12);
    rst_n = 1'b1;
    wt(4);
    rdc(8'h04, 8'h00);
    rdc(8'h20, 8'h00);
    foreach (rows[k]) begin
      xfer(8'h04, rows[k].ph, 1'b0);
      xfer(8'h20, rows[k].cfg, 1'b0);
      rdc(8'h20, rows[k].cfg);
      rgb_in = rows[k].rgb;
      n = -1;
      // latency counted from the first sample pulse that sees the new word
      for (int t = 0; t < 60 && rgb_out !== rows[k].rgb; t++) begin
        wt(1);
        n = n + ((n >= 0 || smp === 1'b1) ? 1 : 0);
      end
      chk(rgb_out, rows[k].rgb);
      // capture, then one pixel per pipeline stage, then the output register
      chk(n, poca_pkg::PIPE_LAT * poca_pkg::PIX_DIV + 1);
      base = rises;
      wt(32);
      chk(rises - base, rows[k].rise);
      chk(got, {rows[k].rgb, 1'b0});
    end
    xfer(8'h13, 8'h02, 1'b0);
    xfer(8'h12, 8'h80, 1'b0);
    wt(8);
    chk(sync_out, 1'b1);
    sync_in = 1'b1;
    n = 0;
    for (int t = 0; t < 80; t++) begin
      wt(1);
      n = n + (sync_out === 1'b0 ? 1 : 0);
    end
    chk(n, 8);
    sync_in = 1'b0;
    xfer(8'h30, 8'h5a, 1'b0);
    rdc(8'h30, 8'h00);
    start;
    xb({poca_pkg::SER_ADDR ^ 7'h01, 1'b0}, 1'b1);
    chk(a, 1);
    stop;
    rst_n = 1'b0;
    wt(3);
    chk({rgb_out, sync_out, strobe, sda_oe_n}, {24'h000000, 3'b001});
    rst_n = 1'b1;
    wt(4);
    rdc(8'h20, 8'h00);
    report_and_stop;
  end
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    report_and_stop;
  end
endmodule : testbench
